// >>> pkg/ccm_pkg.sv
// Purpose: Shared constants and helpers for the compare-mode channel
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Offsets are byte addresses on the register bus
package ccm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMP_VALUE = 8'h00;
    localparam logic [7:0] OFF_MODULE_CTRL = 8'h04;
    localparam logic [7:0] OFF_TIMER_SEL = 8'h08;
    localparam logic [7:0] OFF_PIN_CTRL = 8'h0C;
    localparam logic [7:0] OFF_FLAG = 8'h10;
    localparam logic [7:0] OFF_ENABLE = 8'h14;
    localparam logic [7:0] OFF_PRIORITY = 8'h18;
    localparam logic [7:0] OFF_FLAG_CLR = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    // Mode select field encodings
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_DRIVE_HIGH = 4'h8;
    localparam logic [3:0] MODE_DRIVE_LOW = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    // Field positions
    localparam int unsigned CH4_FLAG_BIT = 1;
    localparam int unsigned PIN_PORT_BIT = 0;
    localparam int unsigned PIN_DIR_BIT = 1;
    // Reset values
    localparam logic [15:0] CMP_VALUE_RESET = 16'h0000;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic PIN_DIR_RESET = 1'b1;
    localparam logic [7:0] BYTE_REG_RESET = 8'h00;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // True for modes in which the comparator runs
    function automatic logic ccm_is_compare_mode(input logic [3:0] mode);
        return (mode == MODE_TOGGLE) || (mode[3:2] == 2'h2);
    endfunction : ccm_is_compare_mode

    // True for byte addresses that hold a register
    function automatic logic ccm_addr_mapped(input logic [7:0] addr);
        logic [7:0] word;
        word = {addr[7:2], 2'h0};
        return (word <= OFF_STATUS);
    endfunction : ccm_addr_mapped

    // Merges write data into an old word under byte strobes
    function automatic logic [31:0] ccm_apply_strb(input logic [31:0] old, input logic [31:0] data,
                                                   input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : ccm_apply_strb
endpackage : ccm_pkg

// >>> rtl/ccm_match.sv
// Purpose: Equality comparator that yields one pulse per match
// Assumes: Timer value synchronous to the clock
// Notes: A timer that rests on the compare value gives a single event
`timescale 1ns/1ps
module ccm_match
    import ccm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic active,
    input wire logic [15:0] compare_value,
    input wire logic [15:0] timer_value,
    output logic match_pulse
);
    logic eq_now;
    logic eq_prev_reg;
    logic eq_prev_next;

    // Compare each cycle, pulse on the first equal cycle
    always_comb begin
        eq_now = active && (timer_value == compare_value);
        eq_prev_next = eq_now;
        match_pulse = eq_now && !eq_prev_reg;
    end

    // Previous equality
    always_ff @(posedge clk) begin
        if (srst) begin
            eq_prev_reg <= 1'b0;
        end else begin
            eq_prev_reg <= eq_prev_next;
        end
    end
endmodule : ccm_match

// >>> rtl/ccm_axil.sv
// Purpose: AXI4-Lite slave front end with register strobes
// Assumes: One write and one read in flight at most
// Notes: Address and data are taken together in one cycle
`timescale 1ns/1ps
module ccm_axil
    import ccm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_en,
    output logic rd_en,
    input wire logic [31:0] rd_word
);
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    // Handshakes and answer channels
    always_comb begin
        wr_en = awvalid && wvalid && !bvalid_reg;
        rd_en = arvalid && !rvalid_reg;
        bvalid_next = bvalid_reg && !bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (wr_en) begin
            bvalid_next = 1'b1;
            bresp_next = ccm_addr_mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rd_en) begin
            rvalid_next = 1'b1;
            rresp_next = ccm_addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_next = rd_word;
        end
    end

    assign awready = wr_en;
    assign wready = wr_en;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;

    // Channel state
    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else begin
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end
endmodule : ccm_axil

// >>> rtl/ccm_top.sv
// Purpose: Compare-mode channel with pin action, flags and event trigger
// Assumes: Timers live outside; their values arrive as ports
// Notes: Other channels' flags enter as set pulses on one port
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// How it works
// - While a compare mode is active the compare value is matched against the chosen timer every cycle.
// - A match drives the compare output high, low, toggles it, or leaves the pin on the port latch.
// - The match flag is set on the same clock edge as the pin action.
// - Writing zero to the control register forces the compare latch low and leaves the port latch alone.
// - In software interrupt mode a match leaves the pin alone and only sets the flag.
// - A software interrupt match reaches the interrupt line only while its enable bit is set.
// - In special event mode every match emits a one-cycle trigger pulse.
// - The trigger clears whichever timer is currently chosen as the time base.
// - This channel's trigger never starts a converter.
// - Flags of channels three to ten sit in one byte, channel three at bit 0.
// - Enable and priority bytes follow the same bit layout as the flags.
module ccm_top
    import ccm_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic [15:0] TIMER_A_VALUE,
    input wire logic [15:0] TIMER_B_VALUE,
    input wire logic [7:0] OTHER_FLAG_SET,
    output logic TIMER_A_CLEAR,
    output logic TIMER_B_CLEAR,
    output logic SPECIAL_EVENT,
    output logic ADC_START,
    output logic PIN_OUT,
    output logic PIN_OE,
    output logic IRQ,
    output logic IRQ_PRIO
);
    logic wr_en, rd_en, match_pulse, compare_active, zero_write;
    logic [31:0] rd_word, wr_old, wr_merged;
    logic [15:0] selected_timer;
    logic [7:0] flag_set;
    logic [15:0] cmp_value_reg, cmp_value_next;
    logic [3:0] mode_reg, mode_next;
    logic timer_sel_reg, timer_sel_next;
    logic port_latch_reg, port_latch_next;
    logic pin_dir_reg, pin_dir_next;
    logic [7:0] flag_reg, flag_next;
    logic [7:0] enable_reg, enable_next;
    logic [7:0] prio_reg, prio_next;
    logic cmp_latch_reg, cmp_latch_next;
    logic pin_out_reg, pin_out_next;
    logic special_reg, special_next;
    logic clear_a_reg, clear_a_next;
    logic clear_b_reg, clear_b_next;

    // Register readback, shared by reads and write merging
    function automatic logic [31:0] reg_read(input logic [7:0] addr);
        logic [31:0] v;
        v = 32'h00000000;
        case ({addr[7:2], 2'h0})
            OFF_CMP_VALUE: v[15:0] = cmp_value_reg;
            OFF_MODULE_CTRL: v[3:0] = mode_reg;
            OFF_TIMER_SEL: v[0] = timer_sel_reg;
            OFF_PIN_CTRL: v[1:0] = {pin_dir_reg, port_latch_reg};
            OFF_FLAG: v[7:0] = flag_reg;
            OFF_ENABLE: v[7:0] = enable_reg;
            OFF_PRIORITY: v[7:0] = prio_reg;
            OFF_STATUS: v[2:0] = {compare_active, pin_out_reg, cmp_latch_reg};
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction : reg_read

    // Bus slave
    ccm_axil u_axil (
        .clk(CLK),
        .srst(SRST),
        .awaddr(AWADDR),
        .awvalid(AWVALID),
        .awready(AWREADY),
        .wdata(WDATA),
        .wstrb(WSTRB),
        .wvalid(WVALID),
        .wready(WREADY),
        .bresp(BRESP),
        .bvalid(BVALID),
        .bready(BREADY),
        .araddr(ARADDR),
        .arvalid(ARVALID),
        .arready(ARREADY),
        .rdata(RDATA),
        .rresp(RRESP),
        .rvalid(RVALID),
        .rready(RREADY),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_word(rd_word)
    );

    // Time base selection and comparator
    assign compare_active = ccm_is_compare_mode(mode_reg);
    assign selected_timer = timer_sel_reg ? TIMER_B_VALUE : TIMER_A_VALUE;

    ccm_match u_match (
        .clk(CLK),
        .srst(SRST),
        .active(compare_active),
        .compare_value(cmp_value_reg),
        .timer_value(selected_timer),
        .match_pulse(match_pulse)
    );

    // Read word and merged write word
    always_comb begin
        rd_word = reg_read(ARADDR);
        wr_old = reg_read(AWADDR);
        wr_merged = ccm_apply_strb(wr_old, WDATA, WSTRB);
        zero_write = wr_en && ({AWADDR[7:2], 2'h0} == OFF_MODULE_CTRL) && (wr_merged == 32'h00000000);
    end

    // Channel four flag from the match, the rest from outside
    always_comb begin
        flag_set = OTHER_FLAG_SET;
        flag_set[CH4_FLAG_BIT] = match_pulse;
    end

    // Software register updates
    always_comb begin
        cmp_value_next = cmp_value_reg;
        mode_next = mode_reg;
        timer_sel_next = timer_sel_reg;
        port_latch_next = port_latch_reg;
        pin_dir_next = pin_dir_reg;
        enable_next = enable_reg;
        prio_next = prio_reg;
        flag_next = flag_reg;
        if (wr_en) begin
            case ({AWADDR[7:2], 2'h0})
                OFF_CMP_VALUE: cmp_value_next = wr_merged[15:0];
                OFF_MODULE_CTRL: mode_next = wr_merged[3:0];
                OFF_TIMER_SEL: timer_sel_next = wr_merged[0];
                OFF_PIN_CTRL: begin
                    port_latch_next = wr_merged[PIN_PORT_BIT];
                    pin_dir_next = wr_merged[PIN_DIR_BIT];
                end
                OFF_FLAG: flag_next = wr_merged[7:0];
                OFF_ENABLE: enable_next = wr_merged[7:0];
                OFF_PRIORITY: prio_next = wr_merged[7:0];
                OFF_FLAG_CLR: begin
                    if (WSTRB[0]) begin
                        flag_next = flag_reg & ~WDATA[7:0];
                    end
                end
                default: flag_next = flag_reg;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        flag_next = flag_next | flag_set;
    end

    // Compare latch, pin and trigger outputs
    always_comb begin
        cmp_latch_next = cmp_latch_reg;
        special_next = 1'b0;
        if (match_pulse) begin
            case (mode_reg)
                MODE_DRIVE_HIGH: cmp_latch_next = 1'b1;
                MODE_DRIVE_LOW: cmp_latch_next = 1'b0;
                MODE_TOGGLE: cmp_latch_next = !cmp_latch_reg;
                MODE_SPECIAL: special_next = 1'b1;
                default: cmp_latch_next = cmp_latch_reg;
            endcase
        end
        if (zero_write) begin
            cmp_latch_next = 1'b0;
        end
        // Pin follows the compare latch only in pin-driving modes
        case (mode_reg)
            MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_TOGGLE: pin_out_next = cmp_latch_next;
            default: pin_out_next = port_latch_reg;
        endcase
        clear_a_next = special_next && !timer_sel_reg;
        clear_b_next = special_next && timer_sel_reg;
    end

    // State registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cmp_value_reg <= CMP_VALUE_RESET;
            mode_reg <= MODE_RESET;
            timer_sel_reg <= 1'b0;
            port_latch_reg <= 1'b0;
            pin_dir_reg <= PIN_DIR_RESET;
            flag_reg <= BYTE_REG_RESET;
            enable_reg <= BYTE_REG_RESET;
            prio_reg <= BYTE_REG_RESET;
            cmp_latch_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            special_reg <= 1'b0;
            clear_a_reg <= 1'b0;
            clear_b_reg <= 1'b0;
        end else begin
            cmp_value_reg <= cmp_value_next;
            mode_reg <= mode_next;
            timer_sel_reg <= timer_sel_next;
            port_latch_reg <= port_latch_next;
            pin_dir_reg <= pin_dir_next;
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            prio_reg <= prio_next;
            cmp_latch_reg <= cmp_latch_next;
            pin_out_reg <= pin_out_next;
            special_reg <= special_next;
            clear_a_reg <= clear_a_next;
            clear_b_reg <= clear_b_next;
        end
    end

    // Outputs
    assign PIN_OUT = pin_out_reg;
    assign PIN_OE = !pin_dir_reg;
    assign SPECIAL_EVENT = special_reg;
    assign TIMER_A_CLEAR = clear_a_reg;
    assign TIMER_B_CLEAR = clear_b_reg;
    assign ADC_START = 1'b0;
    assign IRQ = |(flag_reg & enable_reg);
    assign IRQ_PRIO = |(flag_reg & enable_reg & prio_reg);

    // Checks
    a_match_seen: assert property (@(posedge CLK) disable iff (SRST)
        compare_active && $rose(selected_timer == cmp_value_reg) && $stable(mode_reg) |-> match_pulse)
        else $error("match not detected");
    a_drive_high: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_DRIVE_HIGH && !wr_en |=> PIN_OUT && cmp_latch_reg)
        else $error("pin not driven high");
    a_drive_low: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_DRIVE_LOW && !wr_en |=> !PIN_OUT)
        else $error("pin not driven low");
    a_toggle_pin: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_TOGGLE && !wr_en |=> PIN_OUT != $past(cmp_latch_reg))
        else $error("pin not toggled");
    a_flag_set: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse |=> flag_reg[CH4_FLAG_BIT])
        else $error("match flag not set");
    a_zero_clear: assert property (@(posedge CLK) disable iff (SRST)
        zero_write |=> !cmp_latch_reg && port_latch_reg == $past(port_latch_reg))
        else $error("zero write did not clear latch");
    a_softint_pin: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_SOFT_INT && !wr_en
        |=> PIN_OUT == $past(port_latch_reg) && $stable(cmp_latch_reg))
        else $error("soft interrupt moved the pin");
    a_softint_irq: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_SOFT_INT && enable_reg[CH4_FLAG_BIT] && !wr_en |=> IRQ)
        else $error("enabled soft interrupt not raised");
    a_irq_masked: assert property (@(posedge CLK) disable iff (SRST)
        (flag_reg & enable_reg) == 8'h00 && (OTHER_FLAG_SET & enable_reg) == 8'h00
        && !enable_reg[CH4_FLAG_BIT] && !wr_en |=> !IRQ)
        else $error("interrupt without enabled flag");
    a_special_pulse: assert property (@(posedge CLK) disable iff (SRST)
        match_pulse && mode_reg == MODE_SPECIAL |=> SPECIAL_EVENT ##1 !SPECIAL_EVENT)
        else $error("special trigger not one pulse");
    a_timer_clear: assert property (@(posedge CLK) disable iff (SRST)
        SPECIAL_EVENT |-> (TIMER_B_CLEAR == $past(timer_sel_reg)) && (TIMER_A_CLEAR != TIMER_B_CLEAR))
        else $error("wrong timer cleared");
    a_no_adc: assert property (@(posedge CLK) disable iff (SRST)
        SPECIAL_EVENT |-> !ADC_START)
        else $error("converter started");
    a_flag_layout: assert property (@(posedge CLK) disable iff (SRST)
        OTHER_FLAG_SET[0] |=> flag_reg[0])
        else $error("channel three flag lost");
    a_prio_layout: assert property (@(posedge CLK) disable iff (SRST)
        OTHER_FLAG_SET[7] && enable_reg[7] && prio_reg[7] && !wr_en |=> IRQ_PRIO && IRQ)
        else $error("priority layout broken");

    c_toggle: cover property (@(posedge CLK) disable iff (SRST) match_pulse && mode_reg == MODE_TOGGLE);
    c_special: cover property (@(posedge CLK) disable iff (SRST) SPECIAL_EVENT && TIMER_B_CLEAR);
    c_softint: cover property (@(posedge CLK) disable iff (SRST) match_pulse && mode_reg == MODE_SOFT_INT ##1 IRQ);
    c_set_clear: cover property (@(posedge CLK) disable iff (SRST) match_pulse && wr_en && AWADDR == OFF_FLAG_CLR);
endmodule : ccm_top

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the compare-mode channel
// Assumes: Register bus answers without a fixed latency; ready inputs held high
// Notes: Timer values are driven directly; event outputs counted over a short window
`timescale 1ns/1ps
module testbench
    import ccm_pkg::*;
;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, OTHER_FLAG_SET = 8'h00;
    logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, BREADY = 1'b1, RREADY = 1'b1;
    logic [31:0] WDATA = 32'h0;
    logic [3:0] WSTRB = 4'hF;
    logic [15:0] TIMER_A_VALUE = 16'h0000, TIMER_B_VALUE = 16'h0000;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TIMER_A_CLEAR, TIMER_B_CLEAR;
    logic SPECIAL_EVENT, ADC_START, PIN_OUT, PIN_OE, IRQ, IRQ_PRIO;
    logic [1:0] BRESP, RRESP, resp;
    logic [31:0] RDATA, rword, se_n, ca_n, cb_n, ad_n;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    // Device under test
    ccm_top i_ccm_top (.CLK(CLK), .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .TIMER_A_VALUE(TIMER_A_VALUE),
        .TIMER_B_VALUE(TIMER_B_VALUE), .OTHER_FLAG_SET(OTHER_FLAG_SET), .TIMER_A_CLEAR(TIMER_A_CLEAR),
        .TIMER_B_CLEAR(TIMER_B_CLEAR), .SPECIAL_EVENT(SPECIAL_EVENT), .ADC_START(ADC_START),
        .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .IRQ(IRQ), .IRQ_PRIO(IRQ_PRIO));

    // Clock of 50 ns period
    always #25 CLK = ~CLK;

    // Watchdog against a hung handshake
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end

    // Compares one value and counts it
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // One register write; entered just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        @(posedge CLK);
        while (!(AWREADY && WREADY)) @(posedge CLK);
        AWVALID <= 1'b0;
        WVALID <= 1'b0;
        @(posedge CLK);
        while (!BVALID) @(posedge CLK);
        resp = BRESP;
    endtask : wr

    // One register read, result in rword and resp
    task automatic rd(input logic [7:0] a);
        ARADDR <= a;
        ARVALID <= 1'b1;
        @(posedge CLK);
        while (!ARREADY) @(posedge CLK);
        ARVALID <= 1'b0;
        @(posedge CLK);
        while (!RVALID) @(posedge CLK);
        rword = RDATA;
        resp = RRESP;
    endtask : rd

    // Read and compare a register word
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(name, exp, rword);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : rchk

    // Pin level and interrupt line one cycle on
    task automatic pins(input logic eo, input logic ei);
        @(posedge CLK);
        chk("pin_out", {31'h0, eo}, {31'h0, PIN_OUT});
        chk("irq", {31'h0, ei}, {31'h0, IRQ});
    endtask : pins

    // Timer equals v for one cycle; event outputs counted afterwards
    task automatic hit(input logic tb, input logic [15:0] v);
        se_n = 32'h0;
        ca_n = 32'h0;
        cb_n = 32'h0;
        ad_n = 32'h0;
        if (tb) TIMER_B_VALUE <= v;
        else TIMER_A_VALUE <= v;
        @(posedge CLK);
        TIMER_A_VALUE <= 16'h0000;
        TIMER_B_VALUE <= 16'h0000;
        repeat (6) begin
            @(posedge CLK);
            se_n = se_n + {31'h0, SPECIAL_EVENT};
            ca_n = ca_n + {31'h0, TIMER_A_CLEAR};
            cb_n = cb_n + {31'h0, TIMER_B_CLEAR};
            ad_n = ad_n + {31'h0, ADC_START};
        end
    endtask : hit

    // Main sequence
    initial begin
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        // Reset state and unmapped place
        rchk("ctrl_reset", OFF_MODULE_CTRL, 32'h0);
        rchk("pinctl_reset", OFF_PIN_CTRL, 32'h2);
        rchk("flag_reset", OFF_FLAG, 32'h0);
        chk("oe_reset", 32'h0, {31'h0, PIN_OE});
        rd(8'h40);
        chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped_rdata", 32'h0, rword);
        wr(8'h40, 32'h0000_00FF);
        chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        // Channel set up with pin as output
        wr(OFF_CMP_VALUE, 32'h0000_1234);
        wr(OFF_TIMER_SEL, 32'h0);
        wr(OFF_PIN_CTRL, 32'h0);
        chk("oe_output", 32'h1, {31'h0, PIN_OE});
        // Drive high, then zero write forces compare latch low
        wr(OFF_MODULE_CTRL, {28'h0, MODE_DRIVE_HIGH});
        hit(1'b0, 16'h1234);
        pins(1'b1, 1'b0);
        rchk("status_driven", OFF_STATUS, 32'h7);
        rchk("flag_set", OFF_FLAG, 32'h2);
        wr(OFF_PIN_CTRL, 32'h1);
        wr(OFF_MODULE_CTRL, 32'h0);
        wr(OFF_MODULE_CTRL, {28'h0, MODE_DRIVE_LOW});
        pins(1'b0, 1'b0);
        rchk("port_latch_kept", OFF_PIN_CTRL, 32'h1);
        // Toggle three times, then drive low from high
        wr(OFF_MODULE_CTRL, {28'h0, MODE_TOGGLE});
        hit(1'b0, 16'h1234);
        pins(1'b1, 1'b0);
        hit(1'b0, 16'h1234);
        pins(1'b0, 1'b0);
        hit(1'b0, 16'h1234);
        pins(1'b1, 1'b0);
        wr(OFF_MODULE_CTRL, {28'h0, MODE_DRIVE_LOW});
        hit(1'b0, 16'h1235);
        pins(1'b1, 1'b0);
        hit(1'b0, 16'h1234);
        pins(1'b0, 1'b0);
        // Flag stays until cleared by software
        repeat (20) @(posedge CLK);
        rchk("flag_sticky", OFF_FLAG, 32'h2);
        wr(OFF_FLAG_CLR, 32'h2);
        rchk("flag_cleared", OFF_FLAG, 32'h0);
        // Software interrupt mode, enabled then masked
        wr(OFF_ENABLE, 32'h2);
        wr(OFF_MODULE_CTRL, 32'h0);
        wr(OFF_MODULE_CTRL, {28'h0, MODE_SOFT_INT});
        hit(1'b0, 16'h1234);
        pins(1'b1, 1'b1);
        rchk("soft_flag", OFF_FLAG, 32'h2);
        wr(OFF_PIN_CTRL, 32'h0);
        pins(1'b0, 1'b1);
        wr(OFF_FLAG_CLR, 32'h2);
        pins(1'b0, 1'b0);
        wr(OFF_ENABLE, 32'h0);
        hit(1'b0, 16'h1234);
        pins(1'b0, 1'b0);
        rchk("masked_flag", OFF_FLAG, 32'h2);
        wr(OFF_FLAG_CLR, 32'h2);
        // Special event on timer B; timer A match must be ignored
        wr(OFF_TIMER_SEL, 32'h1);
        wr(OFF_MODULE_CTRL, 32'h0);
        wr(OFF_MODULE_CTRL, {28'h0, MODE_SPECIAL});
        hit(1'b1, 16'h1234);
        chk("special_count", 32'h1, se_n);
        chk("clear_b_count", 32'h1, cb_n);
        chk("clear_a_count", 32'h0, ca_n);
        chk("adc_count", 32'h0, ad_n);
        hit(1'b0, 16'h1234);
        chk("special_unselected", 32'h0, se_n);
        wr(OFF_FLAG_CLR, 32'h2);
        // Flag byte layout, enable and priority
        OTHER_FLAG_SET <= 8'hFF;
        @(posedge CLK);
        OTHER_FLAG_SET <= 8'h00;
        rchk("flag_layout", OFF_FLAG, 32'hFD);
        wr(OFF_ENABLE, 32'h80);
        rchk("enable_back", OFF_ENABLE, 32'h80);
        pins(1'b0, 1'b1);
        wr(OFF_PRIORITY, 32'h80);
        @(posedge CLK);
        chk("irq_prio_on", 32'h1, {31'h0, IRQ_PRIO});
        wr(OFF_PRIORITY, 32'h40);
        @(posedge CLK);
        chk("irq_prio_off", 32'h0, {31'h0, IRQ_PRIO});
        wr(OFF_FLAG_CLR, 32'hFF);
        rchk("flag_all_clear", OFF_FLAG, 32'h0);
        finish_test();
    end
endmodule : testbench
